// >>> adc_host_pkg.sv
// shared constants and carrier types for the converter host controller
package adc_host_pkg;
   localparam int clk_ns = 20;
   // timing figures in nanoseconds
   localparam int rd_conv_ns = 655;
   localparam int cs_gap_ns = 50;
   localparam int pipe_rd_min_ns = 200;
   localparam int pipe_rd_max_ns = 400;
   localparam int wr_done_max_ns = 690;
   localparam int wr_early_rd_ns = 350;
   localparam int wr_early_cyc_ns = 560;
   localparam int wr_gap_ns = 100;
   localparam int wr_cycle_ns = 660;
   localparam int reduced_valid_ns = 705;
   localparam int wr_low_ns = 100;
   // cycle counts: least times round up, pipe_rd_max_ns rounds down, wr_done_max_ns rounds up
   localparam int rd_conv_cyc = (rd_conv_ns + clk_ns - 1) / clk_ns;
   localparam int cs_gap_cyc = (cs_gap_ns + clk_ns - 1) / clk_ns;
   localparam int pipe_rd_cyc = (pipe_rd_min_ns + clk_ns - 1) / clk_ns;
   localparam int pipe_rd_max_cyc = pipe_rd_max_ns / clk_ns;
   localparam int wr_done_cyc = (wr_done_max_ns + clk_ns - 1) / clk_ns;
   localparam int wr_early_cyc = (wr_early_rd_ns + clk_ns - 1) / clk_ns;
   localparam int wr_total_cyc = (wr_early_cyc_ns + clk_ns - 1) / clk_ns;
   localparam int wr_gap_cyc = (wr_gap_ns + clk_ns - 1) / clk_ns;
   localparam int wr_cycle_cyc = (wr_cycle_ns + clk_ns - 1) / clk_ns;
   localparam int reduced_cyc = (reduced_valid_ns + clk_ns - 1) / clk_ns;
   localparam int wr_low_cyc = (wr_low_ns + clk_ns - 1) / clk_ns;
   localparam int cnt_w = 6;
   localparam int data_w = 8;
   localparam int pipe_skip = 2;
   // mode selector: read strobe, pipelined, write-then-read, reduced
   typedef enum logic [1:0] {
      mode_rd = 2'b00,
      mode_pipe = 2'b01,
      mode_wrrd = 2'b10,
      mode_reduced = 2'b11
   } mode_t;
   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic mode;
   } strobes_t;
endpackage

// >>> result_buffer.sv
// two-entry buffer between converter reads and the result consumer
`timescale 1ns/1ps
`default_nettype none
module result_buffer #(
   parameter int width = 8
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [width-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [width-1:0] out_data
);
   logic [width-1:0] mem [2];
   logic [width-1:0] next_mem [2];
   logic wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [1:0] count, next_count;
   logic push, pop;

   // next pointers and storage
   always_comb begin
      push = in_valid && (count != 2'h2);
      pop = out_ready && (count != 2'h0);
      next_mem = mem;
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      if (push) begin
         next_mem[wr_ptr] = in_data;
         next_wr_ptr = ~wr_ptr;
      end
      if (pop) begin
         next_rd_ptr = ~rd_ptr;
      end
      next_count = count + {1'b0, push} - {1'b0, pop};
   end

   // register state
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         mem[0] <= '0;
         mem[1] <= '0;
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
      end else begin
         mem <= next_mem;
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end

   assign in_ready = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data = mem[rd_ptr];
endmodule // result_buffer
`default_nettype wire

// >>> adc_host.sv
// host controller that sequences conversions on the multi-step converter
`timescale 1ns/1ps
`default_nettype none
module adc_host
   import adc_host_pkg::*;
#(
   parameter int width = data_w
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [1:0] mode_sel,
   input wire logic start,
   output logic busy,
   output logic [width-1:0] result,
   output logic result_valid,
   input wire logic result_ready,
   output logic cs_n,
   output logic rd_n,
   output logic wr_n,
   output logic mode_strap,
   input wire logic done_n,
   input wire logic rdy_in,
   output logic rdy_out,
   output logic rdy_oe_n,
   input wire logic [width-1:0] result_bus
);
   typedef enum logic [2:0] {
      st_idle = 3'b000,
      st_rd = 3'b001,
      st_pipe = 3'b010,
      st_wr_low = 3'b011,
      st_wr_wait = 3'b100,
      st_wr_read = 3'b101,
      st_gap = 3'b110
   } state_t;

   state_t state, next_state;
   strobes_t pins, next_pins;
   logic [cnt_w-1:0] cnt, next_cnt;
   logic [1:0] skip, next_skip;
   logic [width-1:0] cap, next_cap;
   logic cap_valid, next_cap_valid;
   logic buf_ready;
   logic buf_valid;
   logic [width-1:0] buf_data;

   // sequencer: strobes, counters, capture of result bus
   always_comb begin
      next_state = state;
      next_pins = pins;
      next_cnt = cnt;
      next_skip = skip;
      next_cap = cap;
      next_cap_valid = cap_valid && !buf_ready;
      next_pins.mode = mode_sel[1];
      case (state)
         st_idle: begin
            next_cnt = '0;
            if (start && !cap_valid) begin
               next_pins.cs_n = 1'b0;
               case (mode_t'(mode_sel))
                  mode_rd: begin
                     next_pins.rd_n = 1'b0;
                     next_state = st_rd;
                  end
                  mode_pipe: begin
                     next_pins.rd_n = 1'b0;
                     next_state = st_pipe;
                  end
                  mode_reduced: begin
                     next_pins.rd_n = 1'b0;
                     next_pins.wr_n = 1'b0;
                     next_state = st_wr_low;
                  end
                  default: begin
                     next_pins.wr_n = 1'b0;
                     next_state = st_wr_low;
                  end
               endcase
            end
         end
         st_rd: begin
            next_cnt = cnt + 1'b1;
            // hold read low until done falls and ready returns high
            if (!done_n && rdy_in
                  && cnt >= cnt_w'(rd_conv_cyc)) begin
               next_cap = result_bus;
               next_cap_valid = 1'b1;
               next_pins.rd_n = 1'b1;
               next_pins.cs_n = 1'b1;
               next_cnt = '0;
               next_state = st_gap;
            end
         end
         st_pipe: begin
            next_cnt = cnt + 1'b1;
            // read pulse inside the 200 to 400 ns window
            if (cnt == cnt_w'(pipe_rd_cyc - 1)) begin
               next_pins.rd_n = 1'b1;
               next_pins.cs_n = 1'b1;
               next_cnt = '0;
               next_state = st_gap;
               if (skip == 2'(pipe_skip)) begin
                  next_cap = result_bus;
                  next_cap_valid = 1'b1;
               end else begin
                  next_skip = skip + 1'b1;
               end
            end
         end
         st_wr_low: begin
            next_cnt = cnt + 1'b1;
            if (cnt == cnt_w'(wr_low_cyc - 1)) begin
               next_pins.wr_n = 1'b1;
               next_cnt = '0;
               next_state = st_wr_wait;
            end
         end
         st_wr_wait: begin
            next_cnt = cnt + 1'b1;
            if (mode_sel == mode_reduced) begin
               // bus already enabled; take data at the valid time
               if (cnt == cnt_w'(reduced_cyc - 1)) begin
                  next_cap = result_bus;
                  next_cap_valid = 1'b1;
                  next_pins.rd_n = 1'b1;
                  next_pins.cs_n = 1'b1;
                  next_cnt = '0;
                  next_state = st_gap;
               end
            end else if (!done_n || cnt == cnt_w'(wr_early_cyc - 1)) begin
               next_pins.rd_n = 1'b0;
               next_state = st_wr_read;
            end
         end
         st_wr_read: begin
            next_cnt = cnt + 1'b1;
            // data valid by the early-read cycle end
            if (!done_n && cnt >= cnt_w'(wr_total_cyc - 1)) begin
               next_cap = result_bus;
               next_cap_valid = 1'b1;
               next_pins.rd_n = 1'b1;
               next_pins.cs_n = 1'b1;
               next_cnt = '0;
               next_state = st_gap;
            end
         end
         st_gap: begin
            next_cnt = cnt + 1'b1;
            if (cnt >= cnt_w'(cs_gap_cyc) && cnt >= cnt_w'(wr_gap_cyc))
               next_state = st_idle;
         end
         default: next_state = st_idle;
      endcase
   end

   // register sequencer state
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state <= st_idle;
         pins <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, mode: 1'b0};
         cnt <= '0;
         skip <= 2'h0;
         cap <= '0;
         cap_valid <= 1'b0;
         busy <= 1'b0;
         result <= '0;
         result_valid <= 1'b0;
      end else begin
         state <= next_state;
         pins <= next_pins;
         cnt <= next_cnt;
         skip <= next_skip;
         cap <= next_cap;
         cap_valid <= next_cap_valid;
         busy <= (next_state != st_idle);
         result <= buf_data;
         result_valid <= buf_valid && !(result_valid && result_ready);
      end
   end

   // converter pins come straight from flops; ready pin never driven
   assign cs_n = pins.cs_n;
   assign rd_n = pins.rd_n;
   assign wr_n = pins.wr_n;
   assign mode_strap = pins.mode;
   assign rdy_out = 1'b0;
   assign rdy_oe_n = 1'b1;

   // captured words queue until the consumer takes them
   result_buffer #(.width(width)) u_buf (
      .mclk(mclk),
      .nrst(nrst),
      .in_valid(cap_valid),
      .in_ready(buf_ready),
      .in_data(cap),
      .out_valid(buf_valid),
      .out_ready(result_ready && result_valid),
      .out_data(buf_data)
   );

   // pipelined read pulse stays within its window
   pipe_width_a: assert property (@(posedge mclk) disable iff (!nrst)
      $fell(rd_n) && state == st_pipe |->
         !rd_n [*8] ##1 !rd_n ##1 !rd_n ##[1:3] rd_n)
      else $error("pipelined read width wrong");
   // gap after chip select rises
   cs_gap_a: assert property (@(posedge mclk) disable iff (!nrst)
      $rose(cs_n) |-> cs_n [*3])
      else $error("chip-select gap too short");
   // early read no sooner than 350 ns: eighteen cycles with read high
   wr_early_a: assert property (@(posedge mclk) disable iff (!nrst)
      $rose(wr_n) && mode_sel == mode_wrrd |->
         rd_n [*8] ##1 rd_n [*8] ##1 rd_n ##1 rd_n)
      else $error("read too early after start");
   // strap follows selected mode
   strap_a: assert property (@(posedge mclk) disable iff (!nrst)
      ##1 mode_strap == $past(mode_sel[1]))
      else $error("strap wrong");
   // start strobe only while chip selected
   wr_cs_a: assert property (@(posedge mclk) disable iff (!nrst)
      !wr_n |-> !cs_n)
      else $error("start strobe without select");
   // read strobe held until done seen
   rd_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
      state == st_rd && done_n |=> !rd_n)
      else $error("read released early");
   // reduced mode keeps read low across start
   reduced_a: assert property (@(posedge mclk) disable iff (!nrst)
      $rose(wr_n) && mode_sel == mode_reduced |-> !rd_n [*8])
      else $error("reduced read released");
   // start strobe pulse width
   wr_low_a: assert property (@(posedge mclk) disable iff (!nrst)
      $fell(wr_n) |-> !wr_n [*5] ##1 wr_n)
      else $error("start pulse width wrong");
   rd_cov: cover property (@(posedge mclk) state == st_rd ##1 state == st_gap);
   pipe_cov: cover property (@(posedge mclk) skip == 2'h2 && $rose(rd_n));
   wr_cov: cover property (@(posedge mclk) state == st_wr_read && !done_n);
   full_cov: cover property (@(posedge mclk) !buf_ready);
endmodule // adc_host
`default_nettype wire

// >>> adc_device_model.sv
// pin-level model of the converter facing the host controller
`timescale 1ns/1ps
`default_nettype none
module adc_device_model
   import adc_host_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic mode_strap,
   output logic done_n,
   output logic rdy_low,
   output logic [7:0] result_bus,
   output int conv_n
);
   logic prev_rd, prev_wr, running;
   logic [7:0] held, out_q;
   int cnt, reads;
   // estimator: six comparators give a section, lower overlap corrected
   function automatic logic [1:0] est_section(input logic [7:0] v);
      logic [5:0] therm;
      int ones;
      logic [1:0] raw;
      ones = 0;
      for (int i = 0; i < 6; i++) begin
         therm[i] = (v >= 8'((2 * i + 3) * 16));
         ones += int'(therm[i]);
      end
      raw = 2'((ones + 1) / 2);
      if (v < {raw, 6'h00}) raw = raw - 2'h1;
      return raw;
   endfunction
   // sampled code: five coarse bits then three fine bits
   function automatic logic [7:0] sample_code(input int n);
      logic [7:0] v;
      v = 8'h40 + 8'(n * 11);
      return {est_section(v), v[5:3], v[2:0]};
   endfunction
   // bus released otherwise; inverted so stale data never matches
   assign result_bus = (!cs_n && !rd_n) ? out_q : ~out_q;
   // open-drain ready pulled low while a read conversion runs
   assign rdy_low = running && !mode_strap;
   // strobe edges start, finish and release conversions
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         prev_rd <= 1'b1;
         prev_wr <= 1'b1;
         running <= 1'b0;
         held <= 8'h00;
         out_q <= 8'h00;
         cnt <= 0;
         reads <= 0;
         conv_n <= 0;
         done_n <= 1'b1;
      end else begin
         prev_rd <= rd_n;
         prev_wr <= wr_n;
         cnt <= cnt + 1;
         if (!mode_strap && prev_rd && !rd_n && !cs_n) begin
            out_q <= (reads < pipe_skip) ? ~out_q : held;
            held <= sample_code(conv_n);
            conv_n <= conv_n + 1;
            reads <= reads + 1;
            running <= 1'b1;
            cnt <= 0;
            done_n <= 1'b1;
         end else if (mode_strap && !prev_wr && wr_n && !cs_n) begin
            held <= sample_code(conv_n);
            conv_n <= conv_n + 1;
            running <= 1'b1;
            cnt <= 0;
            done_n <= 1'b1;
         end else if (mode_strap && prev_rd && !rd_n && running) begin
            out_q <= held;
            running <= 1'b0;
            done_n <= 1'b0;
         end else if (running &&
               cnt >= (mode_strap ? wr_total_cyc : rd_conv_cyc) - 1) begin
            out_q <= held;
            running <= 1'b0;
            done_n <= 1'b0;
         end else if (!prev_rd && rd_n) begin
            done_n <= 1'b1;
         end
      end
   end
endmodule // adc_device_model
`default_nettype wire

// >>> testbench.sv
// self-checking bench for the converter host controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import adc_host_pkg::*;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic [1:0] mode_sel = mode_pipe;
   logic start = 1'b0;
   logic result_ready = 1'b1;
   logic busy, result_valid, cs_n, rd_n, wr_n, mode_strap, done_n;
   logic rdy_out, rdy_oe_n, rdy_low;
   logic [7:0] result, result_bus;
   wire logic rdy_in;
   int conv_n;
   int bad_count = 0;
   int check_count = 0;
   int cycles = 0;
   int rd_lo = 0, cs_hi = 100, wr_hi = 0;
   logic prev_rd = 1'b1, prev_cs = 1'b1;
   // ready line with external pull-up, low if any party sinks
   assign rdy_in = !(rdy_low || (!rdy_oe_n && !rdy_out));
   always #10 mclk = ~mclk;
   adc_host dut_u (.mclk(mclk), .nrst(nrst), .mode_sel(mode_sel),
      .start(start), .busy(busy), .result(result),
      .result_valid(result_valid), .result_ready(result_ready),
      .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .mode_strap(mode_strap),
      .done_n(done_n), .rdy_in(rdy_in), .rdy_out(rdy_out),
      .rdy_oe_n(rdy_oe_n), .result_bus(result_bus));
   adc_device_model model_u (.mclk(mclk), .nrst(nrst), .cs_n(cs_n),
      .rd_n(rd_n), .wr_n(wr_n), .mode_strap(mode_strap),
      .done_n(done_n), .rdy_low(rdy_low), .result_bus(result_bus),
      .conv_n(conv_n));
   task automatic stop_test();
      if (bad_count == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   function automatic logic [7:0] exp_code(input int n);
      return 8'h40 + 8'(n * 11);
   endfunction
   // hang guard
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         stop_test();
      end
   end
   // strobe timing watch on settled levels
   always @(negedge mclk) begin
      if (nrst && prev_rd && !rd_n && mode_sel == mode_wrrd)
         chk(wr_hi >= wr_early_cyc || done_n === 1'b0, "early read");
      if (nrst && !prev_rd && rd_n && mode_sel == mode_rd)
         chk(rd_lo >= rd_conv_cyc, "read released early");
      if (nrst && !prev_rd && rd_n && mode_sel == mode_pipe)
         chk(rd_lo >= pipe_rd_cyc && rd_lo <= pipe_rd_max_cyc, "pulse");
      if (nrst && prev_cs && !cs_n)
         chk(cs_hi >= cs_gap_cyc, "select gap short");
      rd_lo = rd_n ? 0 : rd_lo + 1;
      cs_hi = cs_n ? cs_hi + 1 : 0;
      wr_hi = wr_n ? wr_hi + 1 : 0;
      prev_rd = rd_n;
      prev_cs = cs_n;
   end
   task automatic get_word(output logic [7:0] v);
      int n;
      n = 0;
      while (result_valid !== 1'b1 && n < 400) begin
         @(negedge mclk);
         n++;
      end
      chk(result_valid === 1'b1, "no result");
      v = result;
      @(negedge mclk);
   endtask
   task automatic settle();
      int n;
      n = 0;
      while ((busy !== 1'b0 || result_valid !== 1'b0) && n < 400) begin
         @(negedge mclk);
         n++;
      end
   endtask
   // pipelined reads: two discarded, then previous samples in order
   task automatic pipe_test();
      logic [7:0] a, b, c;
      start = 1'b1;
      get_word(a);
      get_word(b);
      get_word(c);
      start = 1'b0;
      settle();
      chk(a === exp_code(1), "first kept word");
      chk(b === exp_code(2) && c === exp_code(3), "pipe order");
   endtask
   // consumer stalls in read mode; buffer fills and no word is lost
   task automatic stall_test();
      logic [7:0] q[$];
      int n0;
      mode_sel = mode_rd;
      result_ready = 1'b0;
      start = 1'b1;
      repeat (400) @(negedge mclk);
      chk(busy === 1'b0 && result_valid === 1'b1, "full not refused");
      start = 1'b0;
      n0 = conv_n;
      result_ready = 1'b1;
      repeat (20) begin
         if (result_valid === 1'b1) q.push_back(result);
         @(negedge mclk);
      end
      chk(q.size() >= 2, "drained too few");
      if (q.size() >= 2) begin
         chk(q[q.size()-1] === exp_code(n0 - 1), "last word");
         for (int i = 0; i + 1 < q.size(); i++)
            chk(q[i+1] === q[i] + 8'h0b, "word lost");
      end
   endtask
   // single conversion in a given mode
   task automatic one_conv(input mode_t m);
      logic [7:0] v;
      mode_sel = m;
      repeat (2) @(negedge mclk);
      chk(mode_strap === m[1], "strap level");
      chk(rdy_oe_n === 1'b1 && rdy_out === 1'b0, "ready pin driven");
      start = 1'b1;
      @(negedge mclk);
      start = 1'b0;
      get_word(v);
      settle();
      chk(v === exp_code(conv_n - 1), "converted word");
   endtask
   initial begin
      repeat (20) @(negedge mclk);
      nrst = 1'b1;
      @(negedge mclk);
      pipe_test();
      stall_test();
      one_conv(mode_rd);
      one_conv(mode_wrrd);
      one_conv(mode_reduced);
      stop_test();
   end
endmodule // testbench
`default_nettype wire
